// ==== dv/hims_usb_dev_model.sv ====
`timescale 1ns/10ps
`default_nettype none
// Downstream high-speed device: answers each issued transaction after a delay
module hims_usb_dev_model
	import hims_pkg::*;
(
	input  wire logic          clock,
	input  wire logic          reset_n,
	input  wire logic          txn_issue,
	input  wire logic          slow,
	input  wire hims_outcome_s plan,
	output var  logic          txn_done,
	output var  hims_outcome_s txn_outcome
);
	// Quiet at time zero
	initial begin
		txn_done = 1'b0;
		txn_outcome = '0;
	end
	// Prompt or slow answer; outcome lines show a changed pattern once released
	always begin
		@(posedge clock);
		if (reset_n === 1'b1 && txn_issue === 1'b1) begin
			repeat (slow ? 5 + ($urandom % 12) : 1) @(posedge clock);
			txn_done <= 1'b1;
			txn_outcome <= plan;
			@(posedge clock);
			txn_done <= 1'b0;
			txn_outcome <= ~plan;
		end
	end
endmodule : hims_usb_dev_model
`default_nettype wire

// ==== dv/tb_hims_schedule.sv ====
`timescale 1ns/10ps
`default_nettype none
`define HIMS_CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin bad_count++; \
	$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp); end end
module tb_hims_schedule;
	import hims_pkg::*;
	logic          clock = 1'b0, reset_n = 1'b0, uframe_start = 1'b0, sw_wr_en = 1'b0;
	logic          slow = 1'b0, rd_chk = 1'b0;  // Partner pace, read compare strobe
	logic [4:0]    bus_frame = 5'h00;
	logic [2:0]    sw_wr_pair = 3'h0, rd_pair = 3'h0, txn_uframe;
	hims_word_t    sw_wr_data = '0, rd_data;
	logic          txn_issue, txn_done, desc_busy;
	hims_outcome_s plan = '0, txn_outcome;
	logic [63:0]   exp_q[$];                    // Expected results, oldest first
	int            bad_count = 0, check_count = 0;
	// Clock at 25 MHz
	always #20 clock = ~clock;
	hims_schedule dut (.clock(clock), .reset_n(reset_n), .uframe_start(uframe_start),
		.bus_frame(bus_frame), .sw_wr_en(sw_wr_en), .sw_wr_pair(sw_wr_pair),
		.sw_wr_data(sw_wr_data), .rd_pair(rd_pair), .rd_data(rd_data),
		.txn_issue(txn_issue), .txn_uframe(txn_uframe), .txn_done(txn_done),
		.txn_outcome(txn_outcome), .desc_busy(desc_busy));
	hims_usb_dev_model dev (.clock(clock), .reset_n(reset_n), .txn_issue(txn_issue),
		.slow(slow), .plan(plan), .txn_done(txn_done), .txn_outcome(txn_outcome));
	// Oldest note, or unknown when none is waiting
	function automatic logic [63:0] take();
		if (exp_q.size() == 0) return 64'hX;
		return exp_q.pop_front();
	endfunction : take
	// Watcher: every issue and every readback consumes one note
	always @(posedge clock) begin
		if (txn_issue === 1'b1) `HIMS_CHK({61'h0, txn_uframe}, take())
		if (rd_chk) `HIMS_CHK(rd_data, take())
	end
	// Descriptor pair write while the scheduler is idle
	task automatic wr(input logic [2:0] p, input hims_word_t d);
		@(posedge clock);
		sw_wr_en <= 1'b1;
		sw_wr_pair <= p;
		sw_wr_data <= d;
		@(posedge clock);
		sw_wr_en <= 1'b0;
		@(posedge clock);
	endtask : wr
	// Readback with its expectation noted first
	task automatic rd(input logic [2:0] p, input hims_word_t e);
		@(posedge clock);
		rd_pair <= p;
		exp_q.push_back(e);
		@(posedge clock);
		rd_chk <= 1'b1;
		@(posedge clock);
		rd_chk <= 1'b0;
	endtask : rd
	// One frame: load descriptor, run eight microframes, read results back
	task automatic run(input logic [4:0] frm, input hims_mask_t mask, input logic [4:0] bus,
		input logic slw);
		hims_word_t   p4;
		logic [127:0] ex;    // Pair six over pair five
		int           n;
		logic         in;
		hims_count_t  cnt;
		p4 = {32'h0, 24'($urandom), mask};
		ex = '0;
		slow <= slw;
		wr(3'h2, {56'h0, frm, 3'h0});
		wr(3'h4, p4);
		wr(3'h5, 64'h0);
		wr(3'h6, 64'h0);
		for (int u = 0; u < 8; u++) begin
			in = 1'($urandom);
			cnt = in ? 12'($urandom) : 12'h000;
			@(posedge clock);
			plan <= {in, cnt, 3'(u)};
			uframe_start <= 1'b1;
			bus_frame <= bus;
			// Only a matching frame with the bit set is served
			if (frm == bus && mask[u]) begin
				exp_q.push_back(64'(u));
				p4[u] = 1'b0;
				p4[8 + 3 * u +: 3] = in ? 3'(u) & 3'h3 : 3'(u) & 3'h5;
				ex[32 + 12 * u +: 12] = cnt;
			end
			@(posedge clock);
			uframe_start <= 1'b0;
			repeat (3) @(posedge clock);
			n = 0;
			while (desc_busy !== 1'b0 && n < 100) begin
				@(posedge clock);
				n++;
			end
			if (n == 100) bad_count++;
		end
		rd(3'h4, p4);
		rd(3'h5, ex[63:0]);
		rd(3'h6, ex[127:64]);
	endtask : run
	// Counts and verdict
	task automatic close_out();
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : close_out
	// Main sequence: full mask, every fourth, frame mismatch, sparse with slow device
	initial begin
		void'($urandom(32'h447D));
		repeat (2) @(posedge clock);
		reset_n <= 1'b1;
		run(5'h03, 8'hFF, 5'h03, 1'b0);
		run(5'h1C, 8'h11, 5'h1C, 1'b1);
		run(5'h0A, 8'hA5, 5'h0B, 1'b0);
		run(5'h15, 8'h5A, 5'h15, 1'b1);
		close_out();
	end
	// Watchdog well beyond the expected run length
	initial begin
		#400000;
		bad_count++;
		close_out();
	end
endmodule : tb_hims_schedule
`default_nettype wire

// ==== hdl/hims_desc_mem.sv ====
`timescale 1ns/10ps
`default_nettype none
// Copy of descriptor word pairs; read data registered
module hims_desc_mem #(
	parameter int DEPTH = 8
) (
	input  wire logic                 clock,
	input  wire logic                 reset_n,
	input  wire logic                 wr_en,
	input  wire logic [2:0]           wr_addr,
	input  wire hims_pkg::hims_word_t wr_data,
	input  wire logic [2:0]           rd_addr,
	output var  hims_pkg::hims_word_t rd_data
);
	import hims_pkg::*;
	hims_word_t mem [DEPTH];   // Storage array
	// Write port and registered read
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			rd_data <= 64'h0;
		end else begin
			if (wr_en) begin
				mem[wr_addr] <= wr_data;
			end
			rd_data <= mem[rd_addr];
		end
	end
endmodule : hims_desc_mem
`default_nettype wire

// ==== hdl/hims_schedule.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "hims_defs.svh"
module hims_schedule (
	input  wire logic                    clock,
	input  wire logic                    reset_n,
	input  wire logic                    uframe_start,
	input  wire logic [4:0]              bus_frame,
	input  wire logic                    sw_wr_en,
	input  wire logic [2:0]              sw_wr_pair,
	input  wire hims_pkg::hims_word_t    sw_wr_data,
	input  wire logic [2:0]              rd_pair,
	output var  hims_pkg::hims_word_t    rd_data,
	output logic                         txn_issue,
	output logic [2:0]                   txn_uframe,
	input  wire logic                    txn_done,
	input  wire hims_pkg::hims_outcome_s txn_outcome,
	output logic                         desc_busy
);
	import hims_pkg::*;
	// Module state, except the rd_data register and the descriptor memory
	typedef struct packed {
		hims_state_e  state;
		logic [2:0]   uframe;
		logic [2:0]   rd_addr;
		hims_word_t   pair_two;
		hims_word_t   pair_four;
		hims_word_t   pair_five;
		hims_word_t   pair_six;
		hims_wr_s     wr;
		logic         issue;
		logic         busy;
		hims_outcome_s outc;
	} hims_sched_s;
	hims_sched_s s_reg;            // Registered state
	hims_sched_s s_next;           // Next state
	logic        match;            // Frame number match
	hims_mask_t  mask;             // Current activity mask
	hims_result_t res;             // Masked result code
	assign match = (s_reg.pair_two[`HIMS_FRAME_HI:`HIMS_FRAME_LO] == bus_frame);
	assign mask  = s_reg.pair_four[`HIMS_MASK_LO +: `HIMS_UFRAMES];
	// Underrun only for OUT, babble only for IN
	always_comb begin
		res = txn_outcome.result;
		if (txn_outcome.is_in) begin
			res[`HIMS_RES_UNDERRUN] = 1'b0;
		end else begin
			res[`HIMS_RES_BABBLE] = 1'b0;
		end
	end
	// Next state
	always_comb begin
		s_next       = s_reg;
		s_next.issue = 1'b0;
		s_next.wr    = '0;
		// Software descriptor writes update shadow copies
		if (sw_wr_en && s_reg.state == HIMS_IDLE) begin
			case (sw_wr_pair)
				`HIMS_WP_TWO:  s_next.pair_two  = sw_wr_data;
				`HIMS_WP_FOUR: s_next.pair_four = sw_wr_data;
				`HIMS_WP_FIVE: s_next.pair_five = sw_wr_data;
				`HIMS_WP_SIX:  s_next.pair_six  = sw_wr_data;
				default: ;
			endcase
			s_next.wr = '{valid: 1'b1, pair: sw_wr_pair, data: sw_wr_data};
		end
		case (s_reg.state)
			HIMS_IDLE: begin
				// Microframe index advances on each start seen in idle; wraps each frame
				if (uframe_start) begin
					s_next.uframe = s_reg.uframe + 3'h1;
					s_next.state  = HIMS_LOAD;
				end
			end
			HIMS_LOAD: begin
				// Issue only on matching frame with mask bit set
				if (match && mask[s_reg.uframe]) begin
					s_next.issue = 1'b1;
					s_next.busy  = 1'b1;
					s_next.state = HIMS_WAIT;
				end else begin
					s_next.state = HIMS_IDLE;
				end
			end
			HIMS_WAIT: begin
				// Hold results until transaction delivered
				if (txn_done) begin
					s_next.outc  = '{is_in: txn_outcome.is_in, count: txn_outcome.count,
						result: res};
					s_next.state = HIMS_WRITE;
				end
			end
			HIMS_WRITE: begin
				s_next.pair_four[`HIMS_RESULT_LO + `HIMS_RESULT_W * s_reg.uframe +: 3] =
					s_reg.outc.result;
				s_next.pair_four[s_reg.uframe] = 1'b0;
				case (s_reg.uframe)
					3'h0: s_next.pair_five[`HIMS_CNT0_LO +: 12] = s_reg.outc.count;
					3'h1: s_next.pair_five[`HIMS_CNT1_LO +: 12] = s_reg.outc.count;
					3'h2: begin
						s_next.pair_five[`HIMS_CNT2L_LO +: 8] = s_reg.outc.count[7:0];
						s_next.pair_six[`HIMS_CNT2H_LO +: 4]  = s_reg.outc.count[11:8];
					end
					3'h3: s_next.pair_six[`HIMS_CNT3_LO +: 12] = s_reg.outc.count;
					3'h4: s_next.pair_six[`HIMS_CNT4_LO +: 12] = s_reg.outc.count;
					3'h5: begin
						s_next.pair_six[`HIMS_CNT5L_LO +: 4] = s_reg.outc.count[3:0];
						s_next.pair_six[`HIMS_CNT5H_LO +: 8] = s_reg.outc.count[11:4];
					end
					3'h6: s_next.pair_six[`HIMS_CNT6_LO +: 12] = s_reg.outc.count;
					default: s_next.pair_six[`HIMS_CNT7_LO +: 12] = s_reg.outc.count;
				endcase
				s_next.busy  = 1'b0;
				s_next.state = HIMS_IDLE;
			end
			default: s_next.state = HIMS_IDLE;
		endcase
		// Mirror updated pair six into memory after hardware update
		if (s_reg.state == HIMS_WRITE) begin
			s_next.wr = '{valid: 1'b1, pair: `HIMS_WP_SIX, data: s_next.pair_six};
		end
		s_next.rd_addr = rd_pair;
	end
	// State register; index starts at 7 so first start gives 0
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			s_reg        <= '0;
			s_reg.uframe <= 3'h7;
		end else begin
			s_reg <= s_next;
		end
	end
	logic hw_pick;   // Selects memory data for pairs without a live shadow; tied high
	hims_word_t mem_rd;
	hims_desc_mem #(.DEPTH(8)) u_mem (
		.clock   (clock),
		.reset_n (reset_n),
		.wr_en   (s_reg.wr.valid),
		.wr_addr (s_reg.wr.pair),
		.wr_data (s_reg.wr.data),
		.rd_addr (s_reg.rd_addr),
		.rd_data (mem_rd)
	);
	assign hw_pick = 1'b1;
	// Registered read: shadows for live pairs, memory otherwise
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			rd_data <= 64'h0;
		end else begin
			case (rd_pair)
				`HIMS_WP_TWO:  rd_data <= s_reg.pair_two;
				`HIMS_WP_FOUR: rd_data <= s_reg.pair_four;
				`HIMS_WP_FIVE: rd_data <= s_reg.pair_five;
				`HIMS_WP_SIX:  rd_data <= s_reg.pair_six;
				default:       rd_data <= hw_pick ? mem_rd : 64'h0;
			endcase
		end
	end
	assign txn_issue  = s_reg.issue;
	assign txn_uframe = s_reg.uframe;
	assign desc_busy  = s_reg.busy;
	// Issue only on match with mask bit set
	AST_ISSUE_MASK: assert property (@(posedge clock) disable iff (!reset_n)
		txn_issue |-> $past(mask[s_reg.uframe]) && $past(match))
		else $error("issue without mask bit or frame match");
	// Processed bit cleared after write
	AST_MASK_CLEAR: assert property (@(posedge clock) disable iff (!reset_n)
		s_reg.state == HIMS_WRITE |=> !mask[$past(s_reg.uframe)])
		else $error("mask bit not cleared");
	// Result lands after done
	AST_RESULT_AFTER: assert property (@(posedge clock) disable iff (!reset_n)
		(s_reg.state == HIMS_WAIT && txn_done) |=> ##1
		s_reg.pair_four[8 + 3 * s_reg.uframe +: 3] == $past(s_reg.outc.result))
		else $error("result not written");
	// No babble on OUT
	AST_NO_BABBLE_OUT: assert property (@(posedge clock) disable iff (!reset_n)
		(s_reg.state == HIMS_WRITE && !s_reg.outc.is_in) |-> !s_reg.outc.result[1])
		else $error("babble reported on OUT");
	// No underrun on IN
	AST_NO_UNDER_IN: assert property (@(posedge clock) disable iff (!reset_n)
		(s_reg.state == HIMS_WRITE && s_reg.outc.is_in) |-> !s_reg.outc.result[2])
		else $error("underrun reported on IN");
	// Index steps by one per microframe
	AST_INDEX_STEP: assert property (@(posedge clock) disable iff (!reset_n)
		(uframe_start && s_reg.state == HIMS_IDLE) |=> s_reg.uframe == $past(s_reg.uframe) + 3'h1)
		else $error("microframe index did not advance");
	// Mismatch never issues
	AST_NO_MATCH: assert property (@(posedge clock) disable iff (!reset_n)
		(s_reg.state == HIMS_LOAD && !match) |=> !txn_issue)
		else $error("issued on mismatched frame");
	// Microframe 0 count lands in place
	AST_CNT0: assert property (@(posedge clock) disable iff (!reset_n)
		(s_reg.state == HIMS_WRITE && s_reg.uframe == 3'h0) |=>
		s_reg.pair_five[43:32] == $past(s_reg.outc.count))
		else $error("count 0 misplaced");
endmodule : hims_schedule
`default_nettype wire

// ==== inc/hims_defs.svh ====
`ifndef HIMS_DEFS_SVH
`define HIMS_DEFS_SVH
// Descriptor word pairs and field positions
`define HIMS_WP_TWO        3'h2
`define HIMS_WP_FOUR       3'h4
`define HIMS_WP_FIVE       3'h5
`define HIMS_WP_SIX        3'h6
`define HIMS_FRAME_LO      3
`define HIMS_FRAME_HI      7
`define HIMS_MASK_LO       0
`define HIMS_RESULT_LO     8
`define HIMS_RESULT_W      3
`define HIMS_CNT0_LO       32
`define HIMS_CNT1_LO       44
`define HIMS_CNT2L_LO      56
`define HIMS_CNT2H_LO      0
`define HIMS_CNT3_LO       4
`define HIMS_CNT4_LO       16
`define HIMS_CNT5L_LO      28
`define HIMS_CNT5H_LO      32
`define HIMS_CNT6_LO       40
`define HIMS_CNT7_LO       52
`define HIMS_RES_ERR       0
`define HIMS_RES_BABBLE    1
`define HIMS_RES_UNDERRUN  2
`define HIMS_UFRAMES       8
`endif

// ==== inc/hims_pkg.sv ====
package hims_pkg;
	typedef logic [11:0] hims_count_t;
	typedef logic [2:0]  hims_result_t;
	typedef logic [7:0]  hims_mask_t;
	typedef logic [63:0] hims_word_t;
	// Scheduler states
	typedef enum logic [1:0] {HIMS_IDLE, HIMS_LOAD, HIMS_WAIT, HIMS_WRITE} hims_state_e;
	// Outcome of one bus transaction
	typedef struct packed {
		logic         is_in;
		hims_count_t  count;
		hims_result_t result;
	} hims_outcome_s;
	// Write toward descriptor memory
	typedef struct packed {
		logic       valid;
		logic [2:0] pair;
		hims_word_t data;
	} hims_wr_s;
endpackage : hims_pkg
